// ===== core/i2cmts_top.sv
// Master transmit sequencer of the serial port in I2C mode: start, address and data
// bytes with acknowledge capture, stop and repeated start, register port and interrupt.
// Assumes open-drain pads outside; each pin's enable is low while the pin is driven low.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Acknowledge low clears, high sets ack status.
// - Start enable makes Start, then raises flag.
// - Hold start time before further bus action.
// - Buffer write of address starts eight-bit shift.
// - Ack bit shifted in and stored each byte.
// - Flag set at end of ninth clock.
// - Data bytes shift out eight bits, MSB first.
// - Load, shift, ack, flag repeats per byte.
// - Stop or restart enable; flag when done.
// - Buffer full on write, clear after eight.
// - Write while shifting sets collision, buffer kept.
// - After ninth clock hold SCL low, wait.
module i2cmts_top
	import i2cmts_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_scl,
	output logic            o_scl,
	output logic            o_scl_oe_n,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe_n,
	output logic            o_irq
);

	typedef struct packed {
		i2cmts_state_e      fsm;
		logic [7:0]         shift_buffer;
		logic [7:0]         shift_register;
		logic [3:0]         bit_cnt;
		logic [7:0]         baud;
		logic               start_cond_enable;
		logic               restart_cond_enable;
		logic               stop_cond_enable;
		logic               ack_status_bit;
		logic               buffer_full_flag;
		logic               write_collision_flag;
		logic               serial_port_irq_flag;
		logic               load_pending;
		logic [IRQ_BITS-1:0] irq_stat;
		logic [IRQ_BITS-1:0] irq_mask;
		logic               scl_low;
		logic               sda_low;
		logic [7:0]         rdata;
		logic               irq;
	} i2cmts_top_s;

	i2cmts_top_s state_r;
	i2cmts_top_s state_nxt;

	logic scl_level;
	logic sda_level;
	logic tick;
	logic run;

	// Both bus lines are sampled through the three-flop synchroniser.
	i2cmts_sync u_sync_scl (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_async  (i_scl),
		.o_level  (scl_level)
	);

	i2cmts_sync u_sync_sda (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_async  (i_sda),
		.o_level  (sda_level)
	);

	// The generator only runs while a bus phase is in progress.
	// Idle covers the wait after the ninth clock, so SCL stays low and nothing ticks
	// until software writes the next byte; a long pause costs nothing but bus time.
	assign run = (state_r.fsm != ST_IDLE);

	i2cmts_baud u_baud (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_run    (run),
		.i_reload (state_r.baud),
		.o_tick   (tick)
	);

	// Register port, bus sequencing and interrupt in one next-state process.
	always_comb begin
		// Event strobes for this cycle; they only ever set flags, never clear them.
		logic done_evt;
		logic write_collision_flag_evt;
		logic busy;
		done_evt  = 1'b0;
		write_collision_flag_evt  = 1'b0;
		state_nxt = state_r;
		busy      = (state_r.fsm != ST_IDLE);
		state_nxt.rdata = ZERO_BYTE;

		// Register writes.
		if (i_wr) begin
			case (i_addr)
				ADDR_CONTROL: begin
					// Conditions are ignored while another event is in progress.
					if (!busy && !state_r.load_pending) begin
						state_nxt.start_cond_enable   = i_wdata[CTL_START];
						state_nxt.restart_cond_enable = i_wdata[CTL_RESTART];
						state_nxt.stop_cond_enable    = i_wdata[CTL_STOP];
					end
				end
				ADDR_STATUS: begin
					// Software clears the collision and interrupt flags by writing zero; hardware sets win below.
					if (!i_wdata[ST_WRITE_COLLISION_FLAG]) begin
						state_nxt.write_collision_flag = 1'b0;
					end
					if (!i_wdata[ST_IRQ]) begin
						state_nxt.serial_port_irq_flag = 1'b0;
					end
				end
				ADDR_BUFFER: begin
					// A write during a shift is dropped whole; a half-taken byte would corrupt SDA.
					if (busy || state_r.load_pending) begin
						write_collision_flag_evt = 1'b1;
					end else begin
						state_nxt.shift_buffer     = i_wdata;
						state_nxt.buffer_full_flag = 1'b1;
						state_nxt.load_pending     = 1'b1;
					end
				end
				// A new reload value takes effect at the next generator reload, not mid-phase.
				ADDR_BAUD:     state_nxt.baud     = i_wdata;
				ADDR_IRQ_MASK: state_nxt.irq_mask = i_wdata[IRQ_BITS-1:0];
				default: begin
				end
			endcase
		end

		// Register reads; reading the interrupt status clears it.
		// No other read has a side effect, so polling the status register is safe.
		if (i_rd) begin
			case (i_addr)
				ADDR_CONTROL: state_nxt.rdata = {5'h00, state_r.stop_cond_enable,
					state_r.restart_cond_enable, state_r.start_cond_enable};
				ADDR_STATUS: state_nxt.rdata = {3'h0, busy, state_r.serial_port_irq_flag,
					state_r.write_collision_flag, state_r.buffer_full_flag,
					state_r.ack_status_bit};
				ADDR_BUFFER:   state_nxt.rdata = state_r.shift_buffer;
				ADDR_BAUD:     state_nxt.rdata = state_r.baud;
				ADDR_IRQ_STAT: begin
					state_nxt.rdata    = {6'h00, state_r.irq_stat};
					state_nxt.irq_stat = '0;
				end
				ADDR_IRQ_MASK: state_nxt.rdata = {6'h00, state_r.irq_mask};
				default:       state_nxt.rdata = ZERO_BYTE;
			endcase
		end

		// Bus sequencer; every phase lasts at least one generator period and ends on a tick.
		// Several requests can be pending here at once; idle serves start, then restart, then stop, then the buffer.
		case (state_r.fsm)
			ST_IDLE: begin
				if (state_r.start_cond_enable) begin
					state_nxt.sda_low = 1'b0;
					state_nxt.scl_low = 1'b0;
					state_nxt.fsm     = ST_S_SETUP;
				end else if (state_r.restart_cond_enable) begin
					state_nxt.scl_low = 1'b1;
					state_nxt.sda_low = 1'b0;
					state_nxt.fsm     = ST_R_LO;
				end else if (state_r.stop_cond_enable) begin
					state_nxt.scl_low = 1'b1;
					state_nxt.sda_low = 1'b1;
					state_nxt.fsm     = ST_P_LO;
				end else if (state_r.load_pending) begin
					// Transmission begins as soon as the buffer is written.
					state_nxt.shift_register = state_r.shift_buffer;
					state_nxt.load_pending   = 1'b0;
					state_nxt.bit_cnt        = 4'h0;
					state_nxt.scl_low        = 1'b1;
					state_nxt.sda_low        = ~state_r.shift_buffer[7];
					state_nxt.fsm            = ST_BIT_LO;
				end
			end
			ST_R_LO: begin
				// Release SCL with SDA high, then fall into the ordinary start.
				if (tick) begin
					state_nxt.scl_low = 1'b0;
					state_nxt.fsm     = ST_S_SETUP;
				end
			end
			ST_S_SETUP: begin
				// Wait for SCL and SDA high, then pull SDA low while SCL stays high.
				// Another party holding either line low simply delays the start here.
				if (tick && scl_level && sda_level) begin
					state_nxt.sda_low = 1'b1;
					state_nxt.fsm     = ST_S_HOLD;
				end
			end
			ST_S_HOLD: begin
				// The start hold time runs out before SCL falls and the flag rises.
				if (tick) begin
					state_nxt.scl_low             = 1'b1;
					state_nxt.start_cond_enable   = 1'b0;
					state_nxt.restart_cond_enable = 1'b0;
					done_evt                      = 1'b1;
					state_nxt.fsm                 = ST_IDLE;
				end
			end
			ST_BIT_LO: begin
				if (tick) begin
					state_nxt.scl_low = 1'b0;
					state_nxt.fsm     = ST_BIT_HI;
				end
			end
			ST_BIT_HI: begin
				// A slave stretching SCL low holds this phase.
				if (tick && scl_level) begin
					state_nxt.scl_low = 1'b1;
					if (state_r.bit_cnt == BITS_PER_BYTE) begin
						// Ninth clock: acknowledge sampled, then suspend with SCL low.
						// SDA has been stable for the whole high phase, so synchroniser lag is harmless.
						state_nxt.ack_status_bit = sda_level;
						done_evt                 = 1'b1;
						state_nxt.fsm            = ST_IDLE;
					end else begin
						state_nxt.bit_cnt        = state_r.bit_cnt + 4'h1;
						state_nxt.shift_register = {state_r.shift_register[6:0], 1'b0};
						if (state_r.bit_cnt == BITS_PER_BYTE - 4'h1) begin
							// Eighth bit out: buffer empty, SDA released for the ack.
							state_nxt.buffer_full_flag = 1'b0;
							state_nxt.sda_low          = 1'b0;
						end else begin
							state_nxt.sda_low = ~state_r.shift_register[6];
						end
						state_nxt.fsm = ST_BIT_LO;
					end
				end
			end
			ST_P_LO: begin
				if (tick) begin
					state_nxt.scl_low = 1'b0;
					state_nxt.fsm     = ST_P_HI;
				end
			end
			ST_P_HI: begin
				// SDA rises while SCL is high, then the bus is left free.
				// A slave still stretching SCL delays the stop until the clock is truly high.
				if (tick && scl_level) begin
					state_nxt.sda_low          = 1'b0;
					state_nxt.stop_cond_enable = 1'b0;
					done_evt                   = 1'b1;
					state_nxt.fsm              = ST_IDLE;
				end
			end
			default: state_nxt.fsm = ST_IDLE;
		endcase

		// Hardware sets win over a clear in the same cycle.
		if (done_evt) begin
			state_nxt.serial_port_irq_flag = 1'b1;
			state_nxt.irq_stat[IRQ_DONE]   = 1'b1;
		end
		if (write_collision_flag_evt) begin
			state_nxt.write_collision_flag = 1'b1;
			state_nxt.irq_stat[IRQ_WRITE_COLLISION_FLAG]   = 1'b1;
		end
		// Built from the next state so the pin moves on the same edge as the status bits.
		state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask);
	end

	// Control state takes defined values on reset; lines are released.
	// The reload returns to its slow default so a fresh bus is never clocked too fast.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_r      <= '0;
			state_r.fsm  <= ST_IDLE;
			state_r.baud <= BAUD_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Open-drain pins: output always low, enable low while pulling the line down.
	// The data pins never carry a one; a high level is left to the pull-ups.
	assign o_rdata    = state_r.rdata;
	assign o_scl      = 1'b0;
	assign o_scl_oe_n = ~state_r.scl_low;
	assign o_sda      = 1'b0;
	assign o_sda_oe_n = ~state_r.sda_low;
	assign o_irq      = state_r.irq;

endmodule : i2cmts_top
`default_nettype wire

// ===== core/i2cmts_pkg.sv
// Package for the I2C master transmit sequencer: register map, fields, timing.
// Assumes a 200 MHz system clock and a plain address/strobe register port.
package i2cmts_pkg;

	// Register word addresses on the plain register port.
	localparam logic [3:0] ADDR_CONTROL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS    = 4'h1;
	localparam logic [3:0] ADDR_BUFFER    = 4'h2;
	localparam logic [3:0] ADDR_BAUD      = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;

	// Control register (serial_port_control_two) bit positions.
	localparam int CTL_START   = 0;
	localparam int CTL_RESTART = 1;
	localparam int CTL_STOP    = 2;

	// Status register bit positions.
	localparam int ST_ACK      = 0;
	localparam int ST_FULL     = 1;
	localparam int ST_WRITE_COLLISION_FLAG     = 2;
	localparam int ST_IRQ      = 3;
	localparam int ST_BUSY     = 4;

	// Interrupt status bits: completion and write collision.
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_WRITE_COLLISION_FLAG    = 1;
	localparam int IRQ_BITS    = 2;

	// Reset values.
	localparam logic [7:0] BAUD_RESET = 8'h7C;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;

	// Bits per byte, and the acknowledge clock index.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Synchroniser depth for the pins.
	localparam int SYNC_DEPTH = 3;

	// Sequencer states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE    = 8'h01,
		ST_S_SETUP = 8'h02,
		ST_S_HOLD  = 8'h04,
		ST_BIT_LO  = 8'h08,
		ST_BIT_HI  = 8'h10,
		ST_P_LO    = 8'h20,
		ST_P_HI    = 8'h40,
		ST_R_LO    = 8'h80
	} i2cmts_state_e;

endpackage : i2cmts_pkg

// ===== core/i2cmts_sync.sv
// Three-flop input synchroniser with change acceptance when stages two and three agree.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module i2cmts_sync
	import i2cmts_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_resetn,
	input  wire logic i_async,
	output logic      o_level
);

	typedef struct packed {
		logic [SYNC_DEPTH-1:0] pipe;
		logic                  level;
	} i2cmts_sync_s;

	i2cmts_sync_s state_r;
	i2cmts_sync_s state_nxt;

	// The first flop feeds only the second; the output moves when stages two and three agree.
	always_comb begin
		state_nxt       = state_r;
		state_nxt.pipe  = {state_r.pipe[SYNC_DEPTH-2:0], i_async};
		if (state_r.pipe[1] == state_r.pipe[2]) begin
			state_nxt.level = state_r.pipe[2];
		end
	end

	// Idle bus is high, so the stages reset to one.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_r <= '1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_level = state_r.level;

endmodule : i2cmts_sync
`default_nettype wire

// ===== core/i2cmts_baud.sv
// Baud rate generator: one-cycle tick every reload+1 clocks while running.
// Assumes the sequencer clears run whenever the bus clock must be suspended.
`timescale 1ns/1ps
`default_nettype none
module i2cmts_baud
	import i2cmts_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic       i_run,
	input  wire logic [7:0] i_reload,
	output logic            o_tick
);

	typedef struct packed {
		logic [7:0] count;
		logic       tick;
	} i2cmts_baud_s;

	i2cmts_baud_s state_r;
	i2cmts_baud_s state_nxt;

	// Stopping reloads the count, so each phase after a restart lasts a full period.
	always_comb begin
		state_nxt      = state_r;
		state_nxt.tick = 1'b0;
		if (!i_run) begin
			state_nxt.count = i_reload;
		end else if (state_r.count == ZERO_BYTE) begin
			state_nxt.count = i_reload;
			state_nxt.tick  = 1'b1;
		end else begin
			state_nxt.count = state_r.count - 8'h01;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_tick = state_r.tick;

endmodule : i2cmts_baud
`default_nettype wire

// ===== tb/i2cmts_chk.sv
// Checker for the transmit sequencer: bus answers, pin timing and interrupt level.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module i2cmts_chk
	import i2cmts_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_resetn,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       o_scl,
	input wire logic       o_scl_oe_n,
	input wire logic       o_sda,
	input wire logic       o_sda_oe_n,
	input wire logic       o_irq
);
	logic [7:0]  baud_r, mask_r;
	logic [15:0] hi_r, lo_r;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// Shadow baud and mask, and time each clock pin phase, so limits need no body access.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			baud_r <= BAUD_RESET;
			mask_r <= ZERO_BYTE;
			hi_r   <= 16'h0000;
			lo_r   <= 16'h0000;
		end else begin
			if (i_wr && i_addr == ADDR_BAUD) baud_r <= i_wdata;
			if (i_wr && i_addr == ADDR_IRQ_MASK) mask_r <= 8'(i_wdata[IRQ_BITS-1:0]);
			hi_r <= o_scl_oe_n ? hi_r + 16'h0001 : 16'h0000;
			lo_r <= o_scl_oe_n ? 16'h0000 : lo_r + 16'h0001;
		end
	end
	sequence start_s;
		$fell(o_sda_oe_n) && o_scl_oe_n;
	endsequence
	sequence stop_s;
		$rose(o_sda_oe_n) && o_scl_oe_n;
	endsequence
	rdata_idle_a: assert property (!i_rd |=> o_rdata == ZERO_BYTE)
		else $error("read data not zero outside a read");
	rdata_unmap_a: assert property (i_rd && i_addr > ADDR_IRQ_MASK |=> o_rdata == ZERO_BYTE)
		else $error("unmapped read not zero");
	pins_low_a: assert property (o_scl == 1'b0 && o_sda == 1'b0)
		else $error("open-drain data not low");
	irq_mask_a: assert property (o_irq |-> mask_r != ZERO_BYTE)
		else $error("interrupt with all sources masked");
	start_hold_a: assert property (start_s |=> o_scl_oe_n && !o_sda_oe_n)
		else $error("start not held");
	scl_high_a: assert property ($fell(o_scl_oe_n) |-> hi_r > 16'(baud_r))
		else $error("clock high phase too short");
	scl_low_a: assert property ($rose(o_scl_oe_n) |-> lo_r > 16'(baud_r))
		else $error("clock low phase too short");
	stop_idle_a: assert property (stop_s |=> o_scl_oe_n && o_sda_oe_n)
		else $error("bus not idle after stop");
endmodule : i2cmts_chk
`default_nettype wire

// ===== tb/i2cmts_slave.sv
// Behavioural slave on the two-wire bus: takes bytes, acknowledges, may stretch.
// Assumes it samples the resolved wire levels on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module i2cmts_slave (
	input  wire logic       i_clock,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_nack,
	input  wire logic       i_stretch,
	output logic            o_scl_low,
	output logic            o_sda_low,
	output logic      [7:0] o_byte,
	output logic            o_got
);
	logic       scl_d, sda_d;
	logic [3:0] cnt;
	logic [7:0] hold;
	initial begin
		{scl_d, sda_d, o_sda_low, o_got, cnt, hold, o_byte} = 24'hC0_0000;
	end
	// Stretching holds the clock after every fall, so the master must wait for it.
	assign o_scl_low = hold != 8'h00;
	// A start clears the count; rises take bits MSB first; the ninth clock carries the ack.
	always @(posedge i_clock) begin
		scl_d <= i_scl;
		sda_d <= i_sda;
		o_got <= 1'b0;
		if (scl_d && i_scl && sda_d && !i_sda) begin
			cnt <= 4'h0;
		end else if (!scl_d && i_scl) begin
			o_byte <= (cnt < 4'h8) ? {o_byte[6:0], i_sda} : o_byte;
			cnt    <= cnt + 4'h1;
		end else if (scl_d && !i_scl) begin
			o_sda_low <= (cnt == 4'h8) && !i_nack;
			o_got     <= (cnt == 4'h8);
			cnt       <= (cnt == 4'h9) ? 4'h0 : cnt;
			hold      <= i_stretch ? 8'h14 : 8'h00;
		end else if (hold != 8'h00) begin
			hold <= hold - 8'h01;
		end
	end
endmodule : i2cmts_slave
`default_nettype wire

// ===== tb/i2c_master_transmit_sequencer_bench.sv
// Bench for the transmit sequencer: register tasks, result queues, slave model.
// Assumes the checker and slave model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_transmit_sequencer_bench
	import i2cmts_pkg::*;
;
	logic       i_clock, i_resetn, i_wr, i_rd, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_irq;
	logic       scl_w, sda_w, s_scl_low, s_sda_low, nack, stretch, got, rd_seen;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, got_byte, ee, mm;
	logic [7:0] exp_q[$], msk_q[$], byte_q[$];
	int         n_errors, total_checks;
	// Open-drain wires with pull-ups; either party may pull low.
	assign scl_w = (o_scl_oe_n | o_scl) & ~s_scl_low;
	assign sda_w = (o_sda_oe_n | o_sda) & ~s_sda_low;
	i2cmts_top u_i2cmts_top (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl_w),
		.o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_w), .o_sda(o_sda),
		.o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq));
	i2cmts_slave u_i2cmts_slave (.i_clock(i_clock), .i_scl(scl_w), .i_sda(sda_w),
		.i_nack(nack), .i_stretch(stretch), .o_scl_low(s_scl_low), .o_sda_low(s_sda_low),
		.o_byte(got_byte), .o_got(got));
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// One strobe cycle; the gap edge keeps a strobe from being assigned twice at once.
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr    <= w;
		i_rd    <= !w;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic wait_irq();
		int k;
		k = 0;
		while (o_irq !== 1'b1 && k < 3000) begin
			@(posedge i_clock);
			k++;
		end
		check("irq", {7'h00, o_irq}, 8'h01);
	endtask : wait_irq
	task automatic ctl(input int b);
		bus(1'b1, ADDR_CONTROL, 8'(1 << b));
		wait_irq();
		rd(ADDR_CONTROL, 8'h00, 8'h07);
		rd(ADDR_IRQ_STAT, 8'h01, 8'hFF);
		bus(1'b1, ADDR_STATUS, 8'h00);
	endtask : ctl
	// A second buffer write lands mid-shift, so every byte also exercises the collision path.
	task automatic send(input logic [7:0] b, input logic n, input logic s);
		nack    <= n;
		stretch <= s;
		byte_q.push_back(b);
		bus(1'b1, ADDR_BUFFER, b);
		bus(1'b1, ADDR_BUFFER, ~b);
		rd(ADDR_STATUS, 8'h16, 8'h1E);
		rd(ADDR_BUFFER, b, 8'hFF);
		check("irq_masked", {7'h00, o_irq}, 8'h00);
		wait_irq();
		check("scl_hold", {7'h00, o_scl_oe_n}, 8'h00);
		rd(ADDR_IRQ_STAT, 8'h03, 8'hFF);
		rd(ADDR_STATUS, {7'h06, n}, 8'h0F);
		bus(1'b1, ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, 8'h00, 8'h0C);
	endtask : send
	// Each read answer and each byte the slave took is compared with the oldest note.
	always @(posedge i_clock) begin
		if (rd_seen) begin
			ee = exp_q.pop_front();
			mm = msk_q.pop_front();
			check("rdata", o_rdata & mm, ee & mm);
		end
		if (got) begin
			check("byte", got_byte, byte_q.pop_front());
		end
		rd_seen <= i_rd;
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		n_errors++;
		summarize();
	end
	initial begin
		{i_resetn, i_wr, i_rd, nack, stretch} = 5'h00;
		{i_addr, i_wdata} = 12'h000;
		void'($urandom(32'h2b91_4e8d));
		repeat (4) @(posedge i_clock);
		i_resetn <= 1'b1;
		rd(ADDR_BAUD, BAUD_RESET, 8'hFF);
		rd(ADDR_STATUS, 8'h00, 8'hFF);
		rd(4'hF, 8'h00, 8'hFF);
		bus(1'b1, ADDR_BAUD, 8'h03);
		bus(1'b1, ADDR_IRQ_MASK, 8'h01);
		rd(ADDR_IRQ_MASK, 8'h01, 8'hFF);
		ctl(CTL_START);
		for (int i = 0; i < 4; i++) begin
			send(8'($urandom), i == 2, i == 1);
		end
		ctl(CTL_RESTART);
		send(8'($urandom), 1'b0, 1'b1);
		ctl(CTL_STOP);
		repeat (20) @(posedge i_clock);
		check("bytes_left", 8'(byte_q.size()), 8'h00);
		summarize();
	end
endmodule : i2c_master_transmit_sequencer_bench
bind i2cmts_top i2cmts_chk u_i2cmts_chk (.i_clock(i_clock), .i_resetn(i_resetn),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
	.o_irq(o_irq));
`default_nettype wire
